/* serial_peer.sv */
// Purpose: Remote transceiver model, bytes in and out
// Assumes: Byte-wide handshakes on the port clock
// Notes:   Idle data inverts on both outputs; the sending one shows the inverse of its last byte
`timescale 1ns/1ps
module serial_peer (
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                reset,
    // Transmit side
    input  wire logic                tx_serial_valid,
    input  wire logic                tx_ir_valid,
    input  wire logic [7:0]          tx_byte,
    output logic                     tx_ready,
    // Receive side
    output uart_shadow_pkg::rx_char_s rx_serial_char,
    output uart_shadow_pkg::rx_char_s rx_ir_char
);
    logic [8:0] got[$];  // Taken bytes, mode flag on top
    initial begin
        tx_ready       = 1'b0;
        rx_serial_char = '0;
        rx_ir_char     = '0;
    end
    // Record taken bytes with mode
    always @(posedge ref_clk) begin
        if (!reset && tx_ready && (tx_serial_valid || tx_ir_valid)) begin
            got.push_back({tx_ir_valid, tx_byte});
        end
    end
    // Stall or release transmit
    task set_ready(input logic v);
        @(posedge ref_clk);
        tx_ready <= v;
    endtask : set_ready
    // Send n bytes, one a cycle
    task send(input logic ir, input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            if (ir) rx_ir_char <= '{valid: 1'b1, data: b + i[7:0]};
            else rx_serial_char <= '{valid: 1'b1, data: b + i[7:0]};
        end
        @(posedge ref_clk);
        rx_ir_char     <= '{valid: 1'b0, data: ~rx_ir_char.data};
        rx_serial_char <= '{valid: 1'b0, data: ~rx_serial_char.data};
    endtask : send
endmodule : serial_peer

/* tb_uart_shadow_data_port.sv */
// Purpose: Self-checking bench of the shadow port
// Assumes: Peer model and plain bus master
// Notes:   Each scenario judges its own results
`timescale 1ns/1ps
module tb_uart_shadow_data_port;
    logic                      ref_clk = 1'b0;
    logic                      reset   = 1'b1;
    uart_shadow_pkg::bus_req_s bus_req = '0;  // Bus master request
    logic [31:0]               bus_rdata;
    uart_shadow_pkg::rx_char_s rx_serial_char, rx_ir_char;
    logic                      tx_serial_valid, tx_ir_valid, tx_ready, ir_mode, irq;
    logic [7:0]                tx_byte;
    int                        error_cnt = 0;
    int                        checked   = 0;
    localparam logic [31:0]    ST = uart_shadow_pkg::STATUS_OFF;
    localparam logic [31:0]    IS = uart_shadow_pkg::INT_STAT_OFF;
    localparam logic [31:0]    S8 = uart_shadow_pkg::SHADOW_8_OFF;

    always #5 ref_clk = ~ref_clk;

    uart_shadow_data_port dut (.ref_clk, .reset, .bus_req, .bus_rdata, .rx_serial_char, .rx_ir_char,
        .tx_serial_valid, .tx_ir_valid, .tx_byte, .tx_ready, .ir_mode, .irq);
    serial_peer peer (.ref_clk, .reset, .tx_serial_valid, .tx_ir_valid, .tx_byte, .tx_ready, .rx_serial_char,
        .rx_ir_char);

    // Compare and count
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // One write cycle
    task bus_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
    endtask : bus_wr
    // One read, data checked in the answer cycle
    task rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1 check(name, bus_rdata, exp);
    endtask : rd_chk
    // Bounded wait for n taken bytes
    task wait_got(input int n);
        for (int k = 0; k < 60 && peer.got.size() < n; k++) @(posedge ref_clk);
        check("tx count", peer.got.size(), n);
    endtask : wait_got

    // Reset values and refused addresses
    task t_reset();
        rd_chk("shadow reset", S8, 32'h0000_0000);
        rd_chk("status reset", ST, 32'h0000_0020);
        rd_chk("unmapped", 32'h5000_1300, 32'h0000_0000);
        rd_chk("misaligned", 32'h5000_1151, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset
    // Overwrite, overrun, irq mask and clear
    task t_nofifo_rx();
        peer.send(1'b0, 8'h5a, 2);
        rd_chk("overrun status", ST, 32'h0000_0023);
        rd_chk("alias read", uart_shadow_pkg::SHADOW_9_OFF, 32'h0000_005b);
        rd_chk("ready cleared", ST, 32'h0000_0020);
        rd_chk("int events", IS, 32'h0000_0003);
        bus_wr(uart_shadow_pkg::INT_MASK_OFF, 32'h0000_0002);
        #1 check("irq on", irq, 1'b1);
        bus_wr(IS, 32'h0000_0003);
        #1 check("irq off", irq, 1'b0);
        $display("test nofifo rx done");
    endtask : t_nofifo_rx
    // Holding flag clears, second write replaces
    task t_nofifo_tx();
        bus_wr(S8, 32'hffff_ff11);
        rd_chk("holding full", ST, 32'h0000_0000);
        bus_wr(S8, 32'h0000_0022);
        peer.set_ready(1'b1);
        wait_got(1);
        check("replaced byte", peer.got[0], 9'h022);
        rd_chk("holding empty", ST, 32'h0000_0020);
        peer.set_ready(1'b0);
        $display("test nofifo tx done");
    endtask : t_nofifo_tx
    // Fill both FIFOs past full, then drain
    task t_fifo();
        bus_wr(IS, 32'h0000_000f);
        bus_wr(uart_shadow_pkg::CTRL_OFF, 32'h0000_0001);
        for (int i = 0; i < 17; i++) bus_wr(uart_shadow_pkg::SHADOW_BASE + 4 * (i % 16), 32'h80 + i);
        rd_chk("tx full", ST, 32'h0000_0040);
        rd_chk("tx lost", IS, 32'h0000_0008);
        peer.send(1'b0, 8'h30, 17);
        rd_chk("rx full", ST, 32'h0000_0043);
        for (int i = 0; i < 16; i++) rd_chk("rx head", S8, 32'h30 + i);
        peer.set_ready(1'b1);
        wait_got(17);
        for (int i = 0; i < 16; i++) check("tx order", peer.got[1 + i], 9'h080 + i);
        rd_chk("drained", ST, 32'h0000_0020);
        $display("test fifo done");
    endtask : t_fifo
    // Infrared mode swaps input and output
    task t_ir();
        bus_wr(uart_shadow_pkg::CTRL_OFF, 32'h0000_0003);
        #1 check("ir mode", ir_mode, 1'b1);
        peer.send(1'b0, 8'h77, 1);
        peer.send(1'b1, 8'h3c, 1);
        rd_chk("ir byte", S8, 32'h0000_003c);
        rd_chk("ir single", ST, 32'h0000_0020);
        bus_wr(S8, 32'h0000_0096);
        wait_got(18);
        check("ir out", peer.got[17], 9'h196);
        $display("test ir done");
    endtask : t_ir

    // Verdict and end of run
    task end_sim();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    // Main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_nofifo_rx();
        t_nofifo_tx();
        t_fifo();
        t_ir();
        end_sim();
    end
    // Watchdog against a hang
    initial begin
        #50000;
        error_cnt++;
        end_sim();
    end
endmodule : tb_uart_shadow_data_port

/* uart_shadow_data_port.sv */
// Purpose: Shadow receive/transmit data window of a serial port
// Assumes: Deserialiser and serialiser on the same clock, byte-wide handshakes
// Notes:
// Notes on behaviour
// [R1] Sixteen aliased 32-bit words, all behave alike
// [R2] Read returns byte from serial or infrared
// [R3] Read data valid only while data-ready set
// [R4] No FIFO: new byte overwrites, flags overrun
// [R5] FIFO mode: read returns and pops head
// [R6] Full receive FIFO: drop new byte, overrun
// [R7] Write sends on serial or infrared output
// [R8] Master writes only while holding-empty set
// [R9] No FIFO: write clears holding-empty flag
// [R10] No FIFO: later write replaces waiting byte
// [R11] FIFO mode: up to sixteen writes fit
// [R12] Writes into full transmit FIFO are dropped
// [R13] Upper bits read zero, data resets zero
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module uart_shadow_data_port (
    // Clock and reset
    input  wire logic                                  ref_clk,
    input  wire logic                                  reset,
    // Register bus
    input  wire uart_shadow_pkg::bus_req_s             bus_req,
    output logic [uart_shadow_pkg::BUS_W-1:0]          bus_rdata,
    // Receive characters from the deserialisers
    input  wire uart_shadow_pkg::rx_char_s             rx_serial_char,
    input  wire uart_shadow_pkg::rx_char_s             rx_ir_char,
    // Transmit characters to the serialisers
    output logic                                       tx_serial_valid,
    output logic                                       tx_ir_valid,
    output logic [uart_shadow_pkg::DATA_W-1:0]         tx_byte,
    input  wire logic                                  tx_ready,
    // Mode and interrupt
    output logic                                       ir_mode,
    output logic                                       irq
);

    // Control register state
    logic                                   fifo_en_q;
    logic                                   ir_mode_q;
    logic                                   mode_flush;

    // Bus decode
    logic [uart_shadow_pkg::BUS_W-1:0]      shadow_off;
    logic                                   shadow_hit;
    logic                                   shadow_rd;
    logic                                   shadow_wr;
    logic                                   ctrl_wr;
    logic                                   status_rd;

    // Receive path
    uart_shadow_pkg::rx_char_s              rx_char;
    logic [uart_shadow_pkg::DATA_W-1:0]     rx_mem [uart_shadow_pkg::FIFO_DEPTH];
    logic [uart_shadow_pkg::PTR_W-1:0]      rx_rd_ptr_q;
    logic [uart_shadow_pkg::PTR_W-1:0]      rx_wr_ptr_q;
    logic [uart_shadow_pkg::CNT_W-1:0]      rx_cnt_q;
    logic [uart_shadow_pkg::DATA_W-1:0]     receive_buffer_reg_q;
    logic                                   rx_hold_full_q;
    logic                                   rx_full;
    logic                                   rx_push;
    logic                                   rx_pop;
    logic                                   rx_overrun;
    logic                                   rx_data_ready_flag;
    logic                                   overrun_q;
    logic [uart_shadow_pkg::DATA_W-1:0]     shadow_rx_tx_byte;

    // Transmit path
    logic [uart_shadow_pkg::DATA_W-1:0]     tx_mem [uart_shadow_pkg::FIFO_DEPTH];
    logic [uart_shadow_pkg::PTR_W-1:0]      tx_rd_ptr_q;
    logic [uart_shadow_pkg::PTR_W-1:0]      tx_wr_ptr_q;
    logic [uart_shadow_pkg::CNT_W-1:0]      tx_cnt_q;
    logic [uart_shadow_pkg::DATA_W-1:0]     transmit_holding_reg_q;
    logic                                   thr_full_q;
    logic                                   tx_full;
    logic                                   tx_push;
    logic                                   tx_lost;
    logic                                   tx_valid;
    logic                                   tx_take;
    logic                                   tx_holding_empty_flag;
    logic                                   tx_holding_empty_flag_prev_q;

    // Interrupt registers
    logic [uart_shadow_pkg::INT_W-1:0]      int_stat_q;
    logic [uart_shadow_pkg::INT_W-1:0]      int_mask_q;
    logic [uart_shadow_pkg::INT_W-1:0]      int_events;

    // Read data and line status image
    logic [uart_shadow_pkg::BUS_W-1:0]      rdata_q;
    logic [uart_shadow_pkg::BUS_W-1:0]      line_status_reg;

    // Alias window decode: any aligned word in the window
    always_comb begin
        shadow_off = bus_req.addr - uart_shadow_pkg::SHADOW_BASE;
        shadow_hit = (shadow_off < uart_shadow_pkg::SHADOW_SPAN) &&
                     ((bus_req.addr & uart_shadow_pkg::WORD_MASK) == uart_shadow_pkg::WORD_ZERO); // R1
    end

    // Strobes per target
    assign shadow_rd  = bus_req.rd && shadow_hit;
    assign shadow_wr  = bus_req.wr && shadow_hit;
    assign ctrl_wr    = bus_req.wr && (bus_req.addr == uart_shadow_pkg::CTRL_OFF);
    assign status_rd  = bus_req.rd && (bus_req.addr == uart_shadow_pkg::STATUS_OFF);
    // Changing FIFO mode flushes both paths
    assign mode_flush = ctrl_wr && (bus_req.wdata[uart_shadow_pkg::CTRL_FIFO_EN_BIT] != fifo_en_q);

    // Control register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fifo_en_q <= 1'b0;
            ir_mode_q <= 1'b0;
        end else if (ctrl_wr) begin
            fifo_en_q <= bus_req.wdata[uart_shadow_pkg::CTRL_FIFO_EN_BIT];
            ir_mode_q <= bus_req.wdata[uart_shadow_pkg::CTRL_IR_BIT];
        end
    end

    assign ir_mode = ir_mode_q;

    // Receive source follows the mode
    assign rx_char = ir_mode_q ? rx_ir_char : rx_serial_char; // R2

    // Receive FIFO full flag and strobes
    assign rx_full = (rx_cnt_q == uart_shadow_pkg::CNT_FULL);
    assign rx_pop  = shadow_rd && fifo_en_q && (rx_cnt_q != uart_shadow_pkg::CNT_ZERO); // R5
    // A pop in the same cycle frees a slot
    assign rx_push = rx_char.valid && fifo_en_q && (!rx_full || rx_pop);

    // Overrun: unread holding byte or full FIFO
    always_comb begin
        if (fifo_en_q) begin
            rx_overrun = rx_char.valid && rx_full && !rx_pop; // R6
        end else begin
            rx_overrun = rx_char.valid && rx_hold_full_q && !shadow_rd; // R4
        end
    end

    // Receive FIFO storage
    always_ff @(posedge ref_clk) begin
        if (rx_push) begin
            rx_mem[rx_wr_ptr_q] <= rx_char.data;
        end
    end

    // Receive FIFO pointers and count
    always_ff @(posedge ref_clk) begin
        if (reset || mode_flush) begin
            rx_rd_ptr_q <= '0;
            rx_wr_ptr_q <= '0;
            rx_cnt_q    <= uart_shadow_pkg::CNT_ZERO;
        end else begin
            // Pointers advance, count tracks the difference
            if (rx_push) begin
                rx_wr_ptr_q <= rx_wr_ptr_q + uart_shadow_pkg::PTR_ONE;
            end
            if (rx_pop) begin
                rx_rd_ptr_q <= rx_rd_ptr_q + uart_shadow_pkg::PTR_ONE; // R5
            end
            if (rx_push && !rx_pop) begin
                rx_cnt_q <= rx_cnt_q + uart_shadow_pkg::CNT_ONE;
            end else if (rx_pop && !rx_push) begin
                rx_cnt_q <= rx_cnt_q - uart_shadow_pkg::CNT_ONE;
            end
        end
    end

    // Single receive buffer for non-FIFO mode
    always_ff @(posedge ref_clk) begin
        if (reset || mode_flush) begin
            receive_buffer_reg_q <= uart_shadow_pkg::DATA_RESET; // R13
            rx_hold_full_q       <= 1'b0;
        end else if (!fifo_en_q) begin
            if (rx_char.valid) begin
                // New byte wins even over an unread one
                receive_buffer_reg_q <= rx_char.data; // R4
                rx_hold_full_q       <= 1'b1;
            end else if (shadow_rd) begin
                rx_hold_full_q <= 1'b0;
            end
        end
    end

    // Data ready gates what a read means
    assign rx_data_ready_flag = fifo_en_q ? (rx_cnt_q != uart_shadow_pkg::CNT_ZERO) : rx_hold_full_q; // R3

    // Head of the chosen receive store
    assign shadow_rx_tx_byte = fifo_en_q ? rx_mem[rx_rd_ptr_q] : receive_buffer_reg_q; // R5

    // Overrun line status bit, cleared by a status read; set wins
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            overrun_q <= 1'b0;
        end else if (rx_overrun) begin
            overrun_q <= 1'b1; // R6
        end else if (status_rd) begin
            overrun_q <= 1'b0;
        end
    end

    // Transmit FIFO strobes
    assign tx_full = (tx_cnt_q == uart_shadow_pkg::CNT_FULL); // R11
    assign tx_push = shadow_wr && fifo_en_q && !tx_full;
    assign tx_lost = shadow_wr && fifo_en_q && tx_full; // R12

    // Pending character and hand-off to the serialiser
    assign tx_valid = fifo_en_q ? (tx_cnt_q != uart_shadow_pkg::CNT_ZERO) : thr_full_q;
    assign tx_take  = tx_valid && tx_ready;

    // Route to the serial or infrared serialiser
    assign tx_serial_valid = tx_valid && !ir_mode_q; // R7
    assign tx_ir_valid     = tx_valid && ir_mode_q; // R7
    assign tx_byte         = fifo_en_q ? tx_mem[tx_rd_ptr_q] : transmit_holding_reg_q;

    // Transmit FIFO storage; full FIFO leaves contents alone
    always_ff @(posedge ref_clk) begin
        if (tx_push) begin
            tx_mem[tx_wr_ptr_q] <= bus_req.wdata[uart_shadow_pkg::DATA_W-1:0]; // R12
        end
    end

    // Transmit FIFO pointers and count
    always_ff @(posedge ref_clk) begin
        if (reset || mode_flush) begin
            tx_rd_ptr_q <= '0;
            tx_wr_ptr_q <= '0;
            tx_cnt_q    <= uart_shadow_pkg::CNT_ZERO;
        end else begin
            // Push and take may share a cycle
            if (tx_push) begin
                tx_wr_ptr_q <= tx_wr_ptr_q + uart_shadow_pkg::PTR_ONE;
            end
            if (tx_take && fifo_en_q) begin
                tx_rd_ptr_q <= tx_rd_ptr_q + uart_shadow_pkg::PTR_ONE;
            end
            if (tx_push && !(tx_take && fifo_en_q)) begin
                tx_cnt_q <= tx_cnt_q + uart_shadow_pkg::CNT_ONE; // R11
            end else if (!tx_push && tx_take && fifo_en_q) begin
                tx_cnt_q <= tx_cnt_q - uart_shadow_pkg::CNT_ONE;
            end
        end
    end

    // Holding register for non-FIFO mode
    always_ff @(posedge ref_clk) begin
        if (reset || mode_flush) begin
            transmit_holding_reg_q <= uart_shadow_pkg::DATA_RESET; // R13
            thr_full_q             <= 1'b0;
        end else if (!fifo_en_q) begin
            if (shadow_wr) begin
                // Write fills or replaces the waiting byte
                transmit_holding_reg_q <= bus_req.wdata[uart_shadow_pkg::DATA_W-1:0]; // R10
                thr_full_q             <= 1'b1; // R9
            end else if (tx_take) begin
                thr_full_q <= 1'b0;
            end
        end
    end

    // Holding-empty flag per mode
    assign tx_holding_empty_flag = fifo_en_q ? (tx_cnt_q == uart_shadow_pkg::CNT_ZERO) : !thr_full_q; // R9

    // Edge of holding-empty for the interrupt
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tx_holding_empty_flag_prev_q <= 1'b1;
        end else begin
            tx_holding_empty_flag_prev_q <= tx_holding_empty_flag;
        end
    end

    // Interrupt events
    always_comb begin
        int_events                                  = uart_shadow_pkg::INT_RESET;
        int_events[uart_shadow_pkg::INT_RX_BIT]      = rx_char.valid && !rx_overrun;
        int_events[uart_shadow_pkg::INT_OVERRUN_BIT] = rx_overrun; // R4
        int_events[uart_shadow_pkg::INT_TX_HOLDING_EMPTY_FLAG_BIT]    = tx_holding_empty_flag && !tx_holding_empty_flag_prev_q;
        int_events[uart_shadow_pkg::INT_TXLOST_BIT]  = tx_lost; // R12
    end

    // Sticky status, write one to clear; set wins
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            int_stat_q <= uart_shadow_pkg::INT_RESET;
        end else if (bus_req.wr && (bus_req.addr == uart_shadow_pkg::INT_STAT_OFF)) begin
            int_stat_q <= (int_stat_q & ~bus_req.wdata[uart_shadow_pkg::INT_W-1:0]) | int_events;
        end else begin
            int_stat_q <= int_stat_q | int_events;
        end
    end

    // Interrupt mask
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            int_mask_q <= uart_shadow_pkg::INT_RESET;
        end else if (bus_req.wr && (bus_req.addr == uart_shadow_pkg::INT_MASK_OFF)) begin
            int_mask_q <= bus_req.wdata[uart_shadow_pkg::INT_W-1:0];
        end
    end

    // Level interrupt from unmasked status
    assign irq = |(int_stat_q & int_mask_q);

    // Line status image
    always_comb begin
        line_status_reg                                   = uart_shadow_pkg::WORD_ZERO;
        line_status_reg[uart_shadow_pkg::STAT_DR_BIT]     = rx_data_ready_flag; // R3
        line_status_reg[uart_shadow_pkg::STAT_OE_BIT]     = overrun_q;
        line_status_reg[uart_shadow_pkg::STAT_TX_HOLDING_EMPTY_FLAG_BIT]   = tx_holding_empty_flag;
        line_status_reg[uart_shadow_pkg::STAT_TXFULL_BIT] = fifo_en_q && tx_full;
    end

    // Read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_q <= uart_shadow_pkg::WORD_ZERO;
        end else if (!bus_req.rd) begin
            rdata_q <= uart_shadow_pkg::WORD_ZERO;
        end else if (shadow_hit) begin
            // Upper bits of the shadow word read zero
            rdata_q <= {{(uart_shadow_pkg::BUS_W-uart_shadow_pkg::DATA_W){1'b0}}, shadow_rx_tx_byte}; // R13
        end else begin
            unique case (bus_req.addr)
                uart_shadow_pkg::CTRL_OFF: begin
                    rdata_q <= uart_shadow_pkg::WORD_ZERO;
                    rdata_q[uart_shadow_pkg::CTRL_FIFO_EN_BIT] <= fifo_en_q;
                    rdata_q[uart_shadow_pkg::CTRL_IR_BIT]      <= ir_mode_q;
                end
                uart_shadow_pkg::STATUS_OFF: begin
                    rdata_q <= line_status_reg;
                end
                uart_shadow_pkg::INT_STAT_OFF: begin
                    rdata_q <= {{(uart_shadow_pkg::BUS_W-uart_shadow_pkg::INT_W){1'b0}}, int_stat_q};
                end
                uart_shadow_pkg::INT_MASK_OFF: begin
                    rdata_q <= {{(uart_shadow_pkg::BUS_W-uart_shadow_pkg::INT_W){1'b0}}, int_mask_q};
                end
                default: begin
                    // Unmapped address reads zero
                    rdata_q <= uart_shadow_pkg::WORD_ZERO;
                end
            endcase
        end
    end

    assign bus_rdata = rdata_q;

endmodule : uart_shadow_data_port

/* uart_shadow_data_port_props.sv */
// Purpose: Pin checks of the shadow data port
// Assumes: One clock, synchronous reset
// Notes:   Helpers mirror fifo mode and last byte
`timescale 1ns/1ps
module uart_shadow_data_port_chk (
    // Clock and reset
    input wire logic                                ref_clk,
    input wire logic                                reset,
    // Register bus
    input wire uart_shadow_pkg::bus_req_s           bus_req,
    input wire logic [uart_shadow_pkg::BUS_W-1:0]   bus_rdata,
    // Receive and transmit sides
    input wire uart_shadow_pkg::rx_char_s           rx_serial_char,
    input wire uart_shadow_pkg::rx_char_s           rx_ir_char,
    input wire logic                                tx_serial_valid,
    input wire logic                                tx_ir_valid,
    input wire logic [uart_shadow_pkg::DATA_W-1:0]  tx_byte,
    input wire logic                                tx_ready,
    // Mode and interrupt
    input wire logic                                ir_mode,
    input wire logic                                irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff reset;

    logic                      fifo_q;    // Fifo enable mirror
    logic                      seen_q;    // Byte seen since control write
    logic [7:0]                last_q;    // Last received byte
    logic                      shadow_hit; // Aligned alias address
    logic                      tx_valid;  // Any transmit pending
    uart_shadow_pkg::rx_char_s rx_sel;    // Active receive input

    assign shadow_hit = (bus_req.addr - uart_shadow_pkg::SHADOW_BASE) < uart_shadow_pkg::SHADOW_SPAN
        && (bus_req.addr & uart_shadow_pkg::WORD_MASK) == uart_shadow_pkg::WORD_ZERO;
    assign tx_valid = tx_serial_valid | tx_ir_valid;
    assign rx_sel   = ir_mode ? rx_ir_char : rx_serial_char;

    // Follow control writes and arrivals
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fifo_q <= 1'b0;
            seen_q <= 1'b0;
            last_q <= 8'h00;
        end else if (bus_req.wr && bus_req.addr == uart_shadow_pkg::CTRL_OFF) begin
            fifo_q <= bus_req.wdata[0];
            seen_q <= 1'b0;
        end else if (rx_sel.valid) begin
            seen_q <= 1'b1;
            last_q <= rx_sel.data;
        end
    end

    sequence s_shadow_rd;
        bus_req.rd && shadow_hit;
    endsequence
    sequence s_shadow_wr;
        bus_req.wr && shadow_hit;
    endsequence
    sequence s_quiet_rd;
        s_shadow_rd ##0 seen_q && !fifo_q && !rx_sel.valid;
    endsequence

    chk_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0000_0000)
        else $error("idle read data not zero");
    chk_upper_zero: assert property (s_shadow_rd |=> bus_rdata[31:8] == 24'h00_0000)
        else $error("upper bits not zero");
    chk_tx_serial: assert property (tx_serial_valid |-> !ir_mode && !tx_ir_valid)
        else $error("serial send in ir mode");
    chk_tx_ir: assert property (tx_ir_valid |-> ir_mode)
        else $error("ir send in normal mode");
    chk_write_queue: assert property (s_shadow_wr ##0 !tx_valid |=> tx_valid && tx_byte == $past(bus_req.wdata[7:0]))
        else $error("byte not offered");
    chk_write_replace: assert property (s_shadow_wr ##0 !fifo_q |=> tx_valid && tx_byte == $past(bus_req.wdata[7:0]))
        else $error("byte not replaced");
    chk_tx_hold: assert property (tx_valid && !tx_ready && !bus_req.wr |=> tx_valid && $stable(tx_byte))
        else $error("stalled byte lost");
    chk_take_clear: assert property (tx_valid && tx_ready && !fifo_q && !bus_req.wr |=> !tx_valid)
        else $error("holding not emptied");
    chk_rx_latest: assert property (s_quiet_rd |=> bus_rdata[7:0] == $past(last_q))
        else $error("not newest byte");
endmodule : uart_shadow_data_port_chk

bind uart_shadow_data_port uart_shadow_data_port_chk chk_i (.ref_clk, .reset, .bus_req, .bus_rdata,
    .rx_serial_char, .rx_ir_char, .tx_serial_valid, .tx_ir_valid, .tx_byte, .tx_ready, .ir_mode, .irq);

/* uart_shadow_pkg.sv */
// Purpose: Shared constants and types for the shadow data port of a serial port
// Assumes: 32-bit register bus with byte addresses, one clock, synchronous reset
// Notes:   Offsets, field positions and reset values live here only
package uart_shadow_pkg;

    // Widths and depths
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned BUS_W      = 32;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned PTR_W      = 4;
    localparam int unsigned CNT_W      = 5;
    localparam int unsigned INT_W      = 4;

    // Shadow window: sixteen aliased words
    localparam logic [BUS_W-1:0] SHADOW_BASE  = 32'h5000_1130;
    localparam logic [BUS_W-1:0] SHADOW_SPAN  = 32'h0000_0040;
    localparam logic [BUS_W-1:0] WORD_MASK    = 32'h0000_0003;
    localparam logic [BUS_W-1:0] SHADOW_8_OFF = 32'h5000_1150;
    localparam logic [BUS_W-1:0] SHADOW_9_OFF = 32'h5000_1154;

    // Control, status and interrupt registers
    localparam logic [BUS_W-1:0] CTRL_OFF     = 32'h5000_1200;
    localparam logic [BUS_W-1:0] STATUS_OFF   = 32'h5000_1204;
    localparam logic [BUS_W-1:0] INT_STAT_OFF = 32'h5000_1208;
    localparam logic [BUS_W-1:0] INT_MASK_OFF = 32'h5000_120c;

    // Control fields
    localparam int unsigned CTRL_FIFO_EN_BIT = 0;
    localparam int unsigned CTRL_IR_BIT      = 1;

    // Line status fields
    localparam int unsigned STAT_DR_BIT     = 0;
    localparam int unsigned STAT_OE_BIT     = 1;
    localparam int unsigned STAT_TX_HOLDING_EMPTY_FLAG_BIT   = 5;
    localparam int unsigned STAT_TXFULL_BIT = 6;

    // Interrupt event fields
    localparam int unsigned INT_RX_BIT      = 0;
    localparam int unsigned INT_OVERRUN_BIT = 1;
    localparam int unsigned INT_TX_HOLDING_EMPTY_FLAG_BIT    = 2;
    localparam int unsigned INT_TXLOST_BIT  = 3;

    // Reset values and counter constants
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [BUS_W-1:0]  WORD_ZERO  = 32'h0000_0000;
    localparam logic [INT_W-1:0]  INT_RESET  = 4'h0;
    localparam logic [PTR_W-1:0]  PTR_ONE    = 4'h1;
    localparam logic [CNT_W-1:0]  CNT_ONE    = 5'h01;
    localparam logic [CNT_W-1:0]  CNT_ZERO   = 5'h00;
    localparam logic [CNT_W-1:0]  CNT_FULL   = 5'h10;

    // One register bus request
    typedef struct packed {
        logic [BUS_W-1:0] addr;
        logic [BUS_W-1:0] wdata;
        logic             wr;
        logic             rd;
    } bus_req_s;

    // One received character with its strobe
    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
    } rx_char_s;

endpackage : uart_shadow_pkg
